// >>> cell_monitor_cfg_pkg.sv
package cell_monitor_cfg_pkg;

  // ****************************************************************
  // Register bus geometry.
  // ****************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 18;

  // ****************************************************************
  // Register addresses.
  // ****************************************************************
  localparam logic [6:0] ADDR_GENERAL_DEVICE_CONFIG = 7'h01;
  localparam logic [6:0] ADDR_FASTCHARGE_BALANCE_UV = 7'h02;
  localparam logic [6:0] ADDR_BALANCE_CONTROL_1 = 7'h03;
  localparam logic [6:0] ADDR_BALANCE_CONTROL_2 = 7'h04;
  localparam logic [6:0] ADDR_BALANCE_CONTROL_3 = 7'h05;

  // ****************************************************************
  // General device configuration fields.
  // ****************************************************************
  localparam int NODE_ADDRESS_POS = 13;
  localparam int NODE_ADDRESS_W = 5;
  localparam int UPPER_ISO_EN_POS = 12;
  localparam int ISO_AMPLITUDE_POS = 10;
  localparam int ISO_FREQ_POS = 8;
  localparam int PULSE_PERIOD_POS = 4;
  localparam int UPPER_FAULT_RX_POS = 3;
  localparam int HEARTBEAT_EN_POS = 2;
  localparam int TOPMOST_POS = 1;
  localparam int LOWER_FAULT_FORCE_POS = 0;
  localparam logic [2:0] PULSE_PERIOD_RESET = 3'h4;

  // ****************************************************************
  // Fast charge and balance undervoltage fields.
  // ****************************************************************
  localparam int SILENCE_DURATION_POS = 16;
  localparam int FASTCHARGE_TEMP_POS = 8;
  localparam int BALANCE_UV_DELTA_POS = 0;

  // ****************************************************************
  // Balance control fields.
  // ****************************************************************
  localparam int TIMEOUT_DISABLE_POS = 17;
  localparam int LOW_POWER_BAL_POS = 16;
  localparam int BAL_START_POS = 15;
  localparam int BAL_STOP_POS = 14;
  localparam int ELAPSED_TIMER_POS = 7;
  localparam int CELL_THR_W = 7;
  localparam int BAL_MODE_POS = 16;
  localparam int TIMER_RESOLUTION_POS = 15;
  localparam int HIGH_CELL_THR_POS = 8;
  localparam int LOW_CELL_THR_POS = 0;
  localparam int POWERUP_DONE_POS = 17;
  localparam int TRIM_RETRIGGER_POS = 16;
  localparam int WRITE_LOCK_POS = 15;

  // ****************************************************************
  // Timing constants.
  // ****************************************************************
  localparam logic [6:0] ELAPSED_TIMER_MAX = 7'h7F;
  localparam logic [3:0] SLOW_TICK_DIV = 4'h8;
  localparam int HEARTBEAT_UNIT_US = 10;
  localparam int CLOCK_MHZ = 200;
  localparam logic [15:0] HEARTBEAT_UNIT_CYCLES = 16'(HEARTBEAT_UNIT_US * CLOCK_MHZ);

endpackage

// >>> cell_monitor_cfg_balance_regs.sv
`timescale 1ns/1ps
module cell_monitor_cfg_balance_regs
  import cell_monitor_cfg_pkg::*;
(
  // Clock, resets and enable.
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic standby_nrst_i,
  input wire logic ce_i,
  // Register access port.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  // Device status inputs.
  input wire logic powerup_ok_i,
  input wire logic low_power_i,
  input wire logic balance_tick_i,
  input wire logic fault_request_i,
  // Configuration outputs.
  output logic [NODE_ADDRESS_W-1:0] node_address_o,
  output logic addressed_o,
  output logic upper_isolated_port_en_o,
  output logic [1:0] iso_amplitude_o,
  output logic [1:0] iso_freq_o,
  output logic upper_fault_receiver_enable_o,
  output logic topmost_o,
  output logic lower_fault_line_o,
  output logic heartbeat_o,
  output logic [1:0] link_silence_duration_o,
  output logic timeout_supervision_o,
  output logic [7:0] fastcharge_temp_o,
  output logic [7:0] balance_undervoltage_delta_o,
  output logic balancing_o,
  output logic [1:0] balance_mode_o,
  output logic [CELL_THR_W-1:0] top_cell_balance_duration_o,
  output logic [CELL_THR_W-1:0] next_cell_balance_duration_o,
  output logic [CELL_THR_W-1:0] cell12_balance_duration_o,
  output logic [CELL_THR_W-1:0] cell11_balance_duration_o,
  output logic trim_reload_o
);

  // ****************************************************************
  // State of the block.
  // ****************************************************************
  typedef struct packed {
    logic [4:0] node_address;
    logic upper_iso_en;
    logic [1:0] iso_amplitude;
    logic [1:0] iso_freq;
    logic [2:0] pulse_period;
    logic upper_fault_rx;
    logic heartbeat_en;
    logic topmost;
    logic lower_fault_force;
    logic [1:0] silence_duration;
    logic [7:0] fastcharge_temp;
    logic [7:0] uv_delta;
    logic timeout_dis;
    logic low_power_bal;
    logic bal_start;
    logic bal_stop;
    logic balancing;
    logic [6:0] elapsed;
    logic [3:0] slow_div;
    logic [1:0] bal_mode;
    logic timer_res;
    logic [6:0] top_thr;
    logic [6:0] next_thr;
    logic [6:0] cell12_thr;
    logic [6:0] cell11_thr;
    logic powerup_done;
    logic trim_retrigger;
    logic write_lock;
    logic trim_pulse;
    logic [15:0] hb_count;
    logic heartbeat;
    logic lower_fault;
    logic [17:0] rdata;
    logic rvalid;
    logic addressed;
    logic supervision;
  } state_t;

  localparam state_t STATE_RESET = '{pulse_period: PULSE_PERIOD_RESET, supervision: 1'b1,
                                     default: '0};

  state_t state_reg;
  state_t state_next;
  logic [15:0] hb_period;
  logic [17:0] rd_word;
  logic bal_allowed;

  // ****************************************************************
  // Read-back multiplexer.
  // ****************************************************************
  // Unlisted bits stay zero so reserved positions read as zero.
  always_comb
  begin
    rd_word = '0;
    unique case (addr_i)
      ADDR_GENERAL_DEVICE_CONFIG:
      begin
        rd_word[NODE_ADDRESS_POS +: NODE_ADDRESS_W] = state_reg.node_address;
        rd_word[UPPER_ISO_EN_POS] = state_reg.upper_iso_en;
        rd_word[ISO_AMPLITUDE_POS +: 2] = state_reg.iso_amplitude;
        rd_word[ISO_FREQ_POS +: 2] = state_reg.iso_freq;
        rd_word[PULSE_PERIOD_POS +: 3] = state_reg.pulse_period;
        rd_word[UPPER_FAULT_RX_POS] = state_reg.upper_fault_rx;
        rd_word[HEARTBEAT_EN_POS] = state_reg.heartbeat_en;
        rd_word[TOPMOST_POS] = state_reg.topmost;
        rd_word[LOWER_FAULT_FORCE_POS] = state_reg.lower_fault_force;
      end
      ADDR_FASTCHARGE_BALANCE_UV:
      begin
        rd_word[SILENCE_DURATION_POS +: 2] = state_reg.silence_duration;
        rd_word[FASTCHARGE_TEMP_POS +: 8] = state_reg.fastcharge_temp;
        rd_word[BALANCE_UV_DELTA_POS +: 8] = state_reg.uv_delta;
      end
      ADDR_BALANCE_CONTROL_1:
      begin
        rd_word[TIMEOUT_DISABLE_POS] = state_reg.timeout_dis;
        rd_word[LOW_POWER_BAL_POS] = state_reg.low_power_bal;
        rd_word[BAL_START_POS] = state_reg.bal_start;
        rd_word[BAL_STOP_POS] = state_reg.bal_stop;
        rd_word[ELAPSED_TIMER_POS +: CELL_THR_W] = state_reg.elapsed;
      end
      ADDR_BALANCE_CONTROL_2:
      begin
        rd_word[BAL_MODE_POS +: 2] = state_reg.bal_mode;
        rd_word[TIMER_RESOLUTION_POS] = state_reg.timer_res;
        rd_word[HIGH_CELL_THR_POS +: CELL_THR_W] = state_reg.top_thr;
        rd_word[LOW_CELL_THR_POS +: CELL_THR_W] = state_reg.next_thr;
      end
      ADDR_BALANCE_CONTROL_3:
      begin
        rd_word[POWERUP_DONE_POS] = state_reg.powerup_done;
        rd_word[TRIM_RETRIGGER_POS] = state_reg.trim_retrigger;
        rd_word[WRITE_LOCK_POS] = state_reg.write_lock;
        rd_word[HIGH_CELL_THR_POS +: CELL_THR_W] = state_reg.cell12_thr;
        rd_word[LOW_CELL_THR_POS +: CELL_THR_W] = state_reg.cell11_thr;
      end
      default: rd_word = '0;
    endcase
  end

  // Heartbeat period grows linearly with the select code.
  assign hb_period = 16'(HEARTBEAT_UNIT_CYCLES * ({13'h0, state_reg.pulse_period} + 16'h1));
  // Low power freezes the elapsed timer unless explicitly allowed.
  assign bal_allowed = !low_power_i || state_reg.low_power_bal;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.trim_pulse = 1'b0;
    state_next.heartbeat = 1'b0;
    state_next.rvalid = rd_en_i;
    if (rd_en_i)
    begin
      state_next.rdata = rd_word;
    end
    state_next.powerup_done = powerup_ok_i;

    // Register writes; read-only and reserved bits are never written.
    if (wr_en_i)
    begin
      unique case (addr_i)
        ADDR_GENERAL_DEVICE_CONFIG:
        begin
          state_next.node_address = wdata_i[NODE_ADDRESS_POS +: NODE_ADDRESS_W];
          if (!state_reg.write_lock)
          begin
            state_next.upper_iso_en = wdata_i[UPPER_ISO_EN_POS];
            state_next.iso_freq = wdata_i[ISO_FREQ_POS +: 2];
          end
          state_next.iso_amplitude = wdata_i[ISO_AMPLITUDE_POS +: 2];
          state_next.pulse_period = wdata_i[PULSE_PERIOD_POS +: 3];
          state_next.upper_fault_rx = wdata_i[UPPER_FAULT_RX_POS];
          state_next.heartbeat_en = wdata_i[HEARTBEAT_EN_POS];
          state_next.topmost = wdata_i[TOPMOST_POS];
          state_next.lower_fault_force = wdata_i[LOWER_FAULT_FORCE_POS];
        end
        ADDR_FASTCHARGE_BALANCE_UV:
        begin
          state_next.silence_duration = wdata_i[SILENCE_DURATION_POS +: 2];
          state_next.fastcharge_temp = wdata_i[FASTCHARGE_TEMP_POS +: 8];
          state_next.uv_delta = wdata_i[BALANCE_UV_DELTA_POS +: 8];
        end
        ADDR_BALANCE_CONTROL_1:
        begin
          state_next.timeout_dis = wdata_i[TIMEOUT_DISABLE_POS];
          state_next.low_power_bal = wdata_i[LOW_POWER_BAL_POS];
          state_next.bal_start = wdata_i[BAL_START_POS];
          state_next.bal_stop = wdata_i[BAL_STOP_POS];
          // Only the two mixed patterns act; 00 and 11 are ignored.
          if (wdata_i[BAL_START_POS] && !wdata_i[BAL_STOP_POS])
          begin
            state_next.balancing = 1'b1;
            state_next.elapsed = '0;
            state_next.slow_div = '0;
          end
          else if (!wdata_i[BAL_START_POS] && wdata_i[BAL_STOP_POS])
          begin
            state_next.balancing = 1'b0;
          end
        end
        ADDR_BALANCE_CONTROL_2:
        begin
          state_next.bal_mode = wdata_i[BAL_MODE_POS +: 2];
          state_next.timer_res = wdata_i[TIMER_RESOLUTION_POS];
          state_next.top_thr = wdata_i[HIGH_CELL_THR_POS +: CELL_THR_W];
          state_next.next_thr = wdata_i[LOW_CELL_THR_POS +: CELL_THR_W];
        end
        ADDR_BALANCE_CONTROL_3:
        begin
          // Trim reload fires on the rising edge of the sticky bit.
          if (wdata_i[TRIM_RETRIGGER_POS] && !state_reg.trim_retrigger)
          begin
            state_next.trim_pulse = 1'b1;
          end
          // Once set, the bit stays set until main reset.
          state_next.trim_retrigger = state_reg.trim_retrigger | wdata_i[TRIM_RETRIGGER_POS];
          state_next.write_lock = wdata_i[WRITE_LOCK_POS];
          state_next.cell12_thr = wdata_i[HIGH_CELL_THR_POS +: CELL_THR_W];
          state_next.cell11_thr = wdata_i[LOW_CELL_THR_POS +: CELL_THR_W];
        end
        default:
        begin
          state_next.rvalid = rd_en_i;
        end
      endcase
    end

    // Elapsed timer advances on base ticks, or one in eight when slow.
    // Counting from the next value keeps a start that meets a tick from reviving the old count.
    if (state_reg.balancing && bal_allowed && balance_tick_i
        && state_next.elapsed != ELAPSED_TIMER_MAX)
    begin
      if (!state_reg.timer_res || state_next.slow_div == SLOW_TICK_DIV - 4'h1)
      begin
        state_next.elapsed = state_next.elapsed + 7'h1;
        state_next.slow_div = '0;
      end
      else
      begin
        state_next.slow_div = state_next.slow_div + 4'h1;
      end
    end

    // Heartbeat generator runs only while enabled.
    if (!state_reg.heartbeat_en)
    begin
      state_next.hb_count = '0;
    end
    else if (state_reg.hb_count >= hb_period - 16'h1)
    begin
      state_next.hb_count = '0;
      state_next.heartbeat = 1'b1;
    end
    else
    begin
      state_next.hb_count = state_reg.hb_count + 16'h1;
    end

    // Forcing overrides the normal fault request.
    state_next.lower_fault = state_next.lower_fault_force | fault_request_i;

    // Derived outputs are registered as well, so no output carries gate delay.
    state_next.addressed = |state_next.node_address;
    state_next.supervision = !state_next.timeout_dis;

    // Standby reset returns every standby-class field to its reset value, keeps main-class ones.
    if (!standby_nrst_i)
    begin
      state_next = '{pulse_period: PULSE_PERIOD_RESET,
                     iso_freq: state_reg.iso_freq,
                     heartbeat_en: state_reg.heartbeat_en,
                     lower_fault_force: state_reg.lower_fault_force,
                     lower_fault: state_reg.lower_fault_force | fault_request_i,
                     trim_retrigger: state_reg.trim_retrigger,
                     hb_count: state_reg.hb_count,
                     supervision: 1'b1,
                     default: '0};
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Main reset loads STATE_RESET into everything, including main-class fields.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= STATE_RESET;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs, each straight from the state register.
  // ****************************************************************
  assign rdata_o = state_reg.rdata;
  assign rvalid_o = state_reg.rvalid;
  assign node_address_o = state_reg.node_address;
  assign addressed_o = state_reg.addressed;
  assign upper_isolated_port_en_o = state_reg.upper_iso_en;
  assign iso_amplitude_o = state_reg.iso_amplitude;
  assign iso_freq_o = state_reg.iso_freq;
  assign upper_fault_receiver_enable_o = state_reg.upper_fault_rx;
  assign topmost_o = state_reg.topmost;
  assign lower_fault_line_o = state_reg.lower_fault;
  assign heartbeat_o = state_reg.heartbeat;
  assign link_silence_duration_o = state_reg.silence_duration;
  assign timeout_supervision_o = state_reg.supervision;
  assign fastcharge_temp_o = state_reg.fastcharge_temp;
  assign balance_undervoltage_delta_o = state_reg.uv_delta;
  assign balancing_o = state_reg.balancing;
  assign balance_mode_o = state_reg.bal_mode;
  assign top_cell_balance_duration_o = state_reg.top_thr;
  assign next_cell_balance_duration_o = state_reg.next_thr;
  assign cell12_balance_duration_o = state_reg.cell12_thr;
  assign cell11_balance_duration_o = state_reg.cell11_thr;
  assign trim_reload_o = state_reg.trim_pulse;

endmodule // cell_monitor_cfg_balance_regs

// >>> cfg_regs_assertions.sv
`timescale 1ns/1ps
module cfg_regs_assertions
  import cell_monitor_cfg_pkg::*;
(
  // Clock, resets and enable.
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic standby_nrst_i,
  input wire logic ce_i,
  // Register port and watched outputs.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic rd_en_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic fault_request_i,
  input wire logic [NODE_ADDRESS_W-1:0] node_address_o,
  input wire logic lower_fault_line_o,
  input wire logic heartbeat_o,
  input wire logic timeout_supervision_o,
  input wire logic balancing_o,
  input wire logic trim_reload_o
);
  logic trim_wr_reg;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // An access counts only when enabled and not swallowed by the standby reset.
  sequence take_s;
    ce_i && standby_nrst_i;
  endsequence
  sequence wr1_s;
    take_s ##0 wr_en_i && addr_i == ADDR_GENERAL_DEVICE_CONFIG;
  endsequence
  sequence wr3_s;
    take_s ##0 wr_en_i && addr_i == ADDR_BALANCE_CONTROL_1;
  endsequence
  // A reload pulse may only follow a write that set the reload bit.
  always_ff @(posedge clock_i)
    trim_wr_reg <= ce_i && wr_en_i && addr_i == ADDR_BALANCE_CONTROL_3 && wdata_i[16];
  node_mirror_a:
    assert property (wr1_s |=> node_address_o == $past(wdata_i[17:13]))
    else $error("Node address does not follow the write.");
  unmapped_zero_a:
    assert property (take_s ##0 rd_en_i && (addr_i == 7'h00 || addr_i > 7'h05) |=> rdata_o == '0)
    else $error("Unmapped read returned nonzero data.");
  supervision_a:
    assert property (wr3_s |=> timeout_supervision_o == !$past(wdata_i[17]))
    else $error("Timeout supervision does not follow its bit.");
  bal_start_a:
    assert property (wr3_s ##0 wdata_i[15:14] == 2'b10 |=> balancing_o)
    else $error("Start pattern did not start balancing.");
  bal_stop_a:
    assert property (wr3_s ##0 wdata_i[15:14] == 2'b01 |=> !balancing_o)
    else $error("Stop pattern did not stop balancing.");
  bal_hold_a:
    assert property (wr3_s ##0 wdata_i[15] == wdata_i[14] |=> $stable(balancing_o))
    else $error("Neutral pattern changed balancing.");
  fault_req_a:
    assert property (take_s ##0 fault_request_i |=> lower_fault_line_o)
    else $error("Fault request did not raise the lower fault line.");
  beat_pulse_a:
    assert property (heartbeat_o |=> !heartbeat_o [*8])
    else $error("Heartbeat pulse too long or too close.");
  trim_pulse_a:
    assert property (trim_reload_o |-> trim_wr_reg ##1 !trim_reload_o)
    else $error("Reload pulse without a setting write.");
endmodule // cfg_regs_assertions

bind cell_monitor_cfg_balance_regs cfg_regs_assertions chk_i (.clock_i, .nrst_i,
  .standby_nrst_i, .ce_i, .addr_i, .wr_en_i, .wdata_i, .rd_en_i, .rdata_o, .fault_request_i,
  .node_address_o, .lower_fault_line_o, .heartbeat_o, .timeout_supervision_o, .balancing_o,
  .trim_reload_o);

// >>> host_port_model.sv
`timescale 1ns/1ps
module host_port_model
  import cell_monitor_cfg_pkg::*;
(
  // Clock.
  input wire logic clock_i,
  // Requests toward the device.
  output logic [ADDR_W-1:0] addr_o,
  output logic wr_en_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic rd_en_o,
  // Answers from the device.
  input wire logic [DATA_W-1:0] rdata_i,
  input wire logic rvalid_i
);
  // Idle bus from time zero.
  initial
  begin
    {addr_o, wdata_o, wr_en_o, rd_en_o} = '0;
  end
  // Strobe stands one edge; the released bus is inverted so stale data never looks valid.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clock_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Data is taken in the cycle the valid pulse stands; ok stays low if it never comes.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output bit ok);
    @(posedge clock_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clock_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    ok = 1'b0;
    d = '0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      #1;
      ok = (rvalid_i === 1'b1);
      d = rdata_i;
      if (!ok)
        @(posedge clock_i);
    end
  endtask
endmodule // host_port_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top
  import cell_monitor_cfg_pkg::*;
;
  // Stimulus and observed signals.
  logic clock_i, nrst_i, standby_nrst_i, ce_i, wr_en_i, rd_en_i, rvalid_o, powerup_ok_i;
  logic low_power_i, balance_tick_i, fault_request_i, addressed_o, upper_isolated_port_en_o;
  logic upper_fault_receiver_enable_o, topmost_o, lower_fault_line_o, heartbeat_o;
  logic timeout_supervision_o, balancing_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, got;
  logic [4:0] node_address_o;
  logic [1:0] link_silence_duration_o;
  logic [7:0] balance_undervoltage_delta_o;
  logic [6:0] top_cell_balance_duration_o, next_cell_balance_duration_o;
  logic [6:0] cell12_balance_duration_o, cell11_balance_duration_o;
  logic [1:0] iso_amplitude_o, iso_freq_o, balance_mode_o;
  logic [7:0] fastcharge_temp_o;
  logic trim_reload_o;
  int n_fail = 0;
  int n_checks = 0;
  int n;
  bit ok;
  // Device under test; every output is watched.
  cell_monitor_cfg_balance_regs dut (.*);
  // Host side of the register port.
  host_port_model host (.clock_i(clock_i), .addr_o(addr_i), .wr_en_o(wr_en_i),
    .wdata_o(wdata_i), .rd_en_o(rd_en_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o));
  // Clock of 5 ns.
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // Verdict and end of run.
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Single comparison point.
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Read and compare; a lost answer ends the run.
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host.rd(a, got, ok);
    if (!ok)
    begin
      n_fail++;
      end_sim();
    end
    chk(got, exp);
  endtask
  // Balance ticks, one cycle each.
  task automatic tick(input int k);
    repeat (k)
    begin
      @(posedge clock_i);
      balance_tick_i <= 1'b1;
      @(posedge clock_i);
      balance_tick_i <= 1'b0;
    end
  endtask
  // Cycles to the next heartbeat pulse, bounded.
  task automatic beat_gap(output int k);
    k = 0;
    do
    begin
      @(posedge clock_i);
      #1;
      k++;
    end
    while (heartbeat_o !== 1'b1 && k < 5000);
    if (k >= 5000)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  // Main sequence.
  initial
  begin
    {nrst_i, standby_nrst_i, low_power_i, balance_tick_i, fault_request_i} = '0;
    ce_i = 1'b1;
    powerup_ok_i = 1'b1;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    standby_nrst_i <= 1'b1;
    rc(ADDR_GENERAL_DEVICE_CONFIG, 18'h00040);
    rc(ADDR_FASTCHARGE_BALANCE_UV, 18'h00000);
    rc(ADDR_BALANCE_CONTROL_1, 18'h00000);
    rc(ADDR_BALANCE_CONTROL_2, 18'h00000);
    rc(ADDR_BALANCE_CONTROL_3, 18'h20000);
    chk(18'({upper_isolated_port_en_o, upper_fault_receiver_enable_o}), 18'h0);
    host.wr(7'h06, 18'h3FFFF);
    rc(7'h06, 18'h00000);
    rc(7'h00, 18'h00000);
    $display("test reset and unmapped done");
    host.wr(ADDR_GENERAL_DEVICE_CONFIG, 18'h3FFFF);
    rc(ADDR_GENERAL_DEVICE_CONFIG, 18'h3FF7F);
    chk(18'({node_address_o, addressed_o, upper_isolated_port_en_o}), 18'h7F);
    chk(18'({upper_fault_receiver_enable_o, topmost_o}), 18'h3);
    chk(18'({iso_amplitude_o, iso_freq_o}), 18'hF);
    host.wr(ADDR_FASTCHARGE_BALANCE_UV, 18'h3FFFF);
    rc(ADDR_FASTCHARGE_BALANCE_UV, 18'h3FFFF);
    chk(18'({link_silence_duration_o, balance_undervoltage_delta_o}), 18'h3FF);
    chk(18'(fastcharge_temp_o), 18'hFF);
    host.wr(ADDR_BALANCE_CONTROL_2, 18'h3FFFF);
    rc(ADDR_BALANCE_CONTROL_2, 18'h3FF7F);
    chk(18'({top_cell_balance_duration_o, next_cell_balance_duration_o}), 18'h3FFF);
    chk(18'(balance_mode_o), 18'h3);
    $display("test fields done");
    host.wr(ADDR_BALANCE_CONTROL_1, 18'h0807F);
    tick(8);
    rc(ADDR_BALANCE_CONTROL_1, 18'h08080);
    host.wr(ADDR_BALANCE_CONTROL_2, 18'h00000);
    tick(5);
    rc(ADDR_BALANCE_CONTROL_1, 18'h08300);
    low_power_i <= 1'b1;
    tick(3);
    rc(ADDR_BALANCE_CONTROL_1, 18'h08300);
    host.wr(ADDR_BALANCE_CONTROL_1, 18'h1C07F);
    tick(2);
    rc(ADDR_BALANCE_CONTROL_1, 18'h1C400);
    host.wr(ADDR_BALANCE_CONTROL_1, 18'h24000);
    #1;
    chk(18'({balancing_o, timeout_supervision_o}), 18'h0);
    host.wr(ADDR_BALANCE_CONTROL_1, 18'h00000);
    #1;
    chk(18'({balancing_o, timeout_supervision_o}), 18'h1);
    low_power_i <= 1'b0;
    $display("test balancing done");
    host.wr(ADDR_BALANCE_CONTROL_3, 18'h1FF7F);
    #1;
    chk(18'(trim_reload_o), 18'h1);
    rc(ADDR_BALANCE_CONTROL_3, 18'h3FF7F);
    chk(18'({cell12_balance_duration_o, cell11_balance_duration_o}), 18'h3FFF);
    host.wr(ADDR_GENERAL_DEVICE_CONFIG, 18'h00000);
    rc(ADDR_GENERAL_DEVICE_CONFIG, 18'h01300);
    chk(18'(upper_isolated_port_en_o), 18'h1);
    host.wr(ADDR_BALANCE_CONTROL_3, 18'h00000);
    rc(ADDR_BALANCE_CONTROL_3, 18'h30000);
    host.wr(ADDR_GENERAL_DEVICE_CONFIG, 18'h3FFFF);
    @(posedge clock_i);
    standby_nrst_i <= 1'b0;
    @(posedge clock_i);
    standby_nrst_i <= 1'b1;
    rc(ADDR_GENERAL_DEVICE_CONFIG, 18'h00345);
    rc(ADDR_FASTCHARGE_BALANCE_UV, 18'h00000);
    rc(ADDR_BALANCE_CONTROL_3, 18'h30000);
    $display("test lock and standby done");
    host.wr(ADDR_GENERAL_DEVICE_CONFIG, 18'h00000);
    host.wr(ADDR_GENERAL_DEVICE_CONFIG, 18'h00005);
    beat_gap(n);
    beat_gap(n);
    chk(18'(n), 18'd2000);
    chk(18'(lower_fault_line_o), 18'h1);
    host.wr(ADDR_GENERAL_DEVICE_CONFIG, 18'h00000);
    #1;
    chk(18'(lower_fault_line_o), 18'h0);
    @(posedge clock_i);
    fault_request_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk(18'(lower_fault_line_o), 18'h1);
    $display("test heartbeat and fault line done");
    // A write while the clock enable is low must leave the register untouched.
    @(posedge clock_i);
    ce_i <= 1'b0;
    host.wr(ADDR_FASTCHARGE_BALANCE_UV, 18'h00055);
    ce_i <= 1'b1;
    rc(ADDR_FASTCHARGE_BALANCE_UV, 18'h00000);
    $display("test clock enable done");
    end_sim();
  end
endmodule // tb_top
